// ### pcd_pkg.sv
package pcd_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   // Reference clock edges per master clock period (master runs at half rate)
   localparam int MCLK_REF_CYCLES = 2;
   // Master clock cycles the oscillator needs to settle
   localparam int STAB_MCLK_CYCLES = 8000;
   localparam int STAB_REF_CYCLES = STAB_MCLK_CYCLES * MCLK_REF_CYCLES;
   // Nonvolatile write busy time in reference cycles
   localparam int EE_BUSY_REF_CYCLES = 40000;
   localparam int HALF_W = 14;
   // ----------------------------------------
   // Register layout and reset values
   // ----------------------------------------
   localparam logic [15:0] MUX_RST = 16'h1800;
   localparam logic [15:0] DIV_RST = 16'h0000;
   localparam logic [7:0] BUS_RST = 8'h00;
   localparam int MODE_LSB = 6;
   localparam int MODE_MSB = 14;
   localparam int N_LSB = 6;
   localparam int N_MSB = 15;
   localparam int BUS_WC_BIT = 3;
   localparam int BUS_SEL_MSB = 2;
   // ----------------------------------------
   // Serial command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_DIV = 8'h01;
   localparam logic [7:0] CMD_MUX = 8'h02;
   localparam logic [7:0] CMD_BUS = 8'h0D;
   localparam logic [7:0] CMD_COMMIT = 8'h3F;
   // Device type code; value is arbitrary
   localparam logic [3:0] TYPE_CODE_DFLT = 4'h6;
   // ----------------------------------------
   // Input synchroniser lanes and idle levels
   // ----------------------------------------
   localparam int IX_SCL = 0;
   localparam int IX_SDA = 1;
   localparam int IX_PA = 2;
   localparam int IX_PB = 3;
   localparam logic [3:0] SYNC_RST = 4'h3;
   // Mode fields of the output control word, msb first
   typedef struct packed {
      logic pdn_b;
      logic pdn_a;
      logic src_sel;
      logic en_mode;
      logic [1:0] ref_pre;
      logic [1:0] main_pre;
      logic bypass;
   } pcd_mode_t;
   typedef enum logic [3:0] {
      PW_WARM = 4'h1,
      PW_ACT = 4'h2,
      PW_DRAIN = 4'h4,
      PW_DOWN = 4'h8
   } pcd_pw_t;
   typedef enum logic [4:0] {
      I_IDLE = 5'h01,
      I_RX = 5'h02,
      I_ACK = 5'h04,
      I_TX = 5'h08,
      I_RACK = 5'h10
   } pcd_i2c_t;
   // Prescaler code to half-period in reference cycles: 1, 2, 4, 8
   function automatic logic [3:0] pre_half(input logic [1:0] code);
      return 4'(4'h1 << code);
   endfunction
endpackage

// ### pcd_clk_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_clk_gen import pcd_pkg::*; #(
   parameter int W = HALF_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_run,
   input wire logic [W-1:0] i_half,
   output logic o_clk
);
   // ----------------------------------------
   // Square wave generator
   // ----------------------------------------
   logic [W-1:0] cnt_ff; // Cycles spent in the current phase
   logic [W-1:0] half_ff; // Half period in use for this whole period
   logic clk_ff; // Output level

   // Period is 2*half reference cycles; while running, the new half only loads as a low
   // phase ends, so a setting change never leaves a runt pulse
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= '0;
         half_ff <= W'(1);
         clk_ff <= 1'b0;
      end else if (!i_run) begin
         // Stopped: parked low, ready to start a fresh period
         cnt_ff <= '0;
         half_ff <= i_half;
         clk_ff <= 1'b0;
      end else if (cnt_ff == half_ff - W'(1)) begin
         cnt_ff <= '0;
         clk_ff <= ~clk_ff;
         if (!clk_ff) begin
            half_ff <= (i_half == '0) ? W'(1) : i_half; // R28
         end
      end else begin
         cnt_ff <= cnt_ff + W'(1);
      end
   end

   assign o_clk = clk_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_phase_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R1
      (i_run && $past(i_run) && $changed(clk_ff)) |-> $past(cnt_ff) == $past(half_ff) - W'(1))
      else $error("phase ended at the wrong count");
   chk_no_runt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R28
      ($changed(half_ff) && i_run && $past(i_run)) |-> $rose(clk_ff))
      else $error("half period changed mid period");
endmodule
`default_nettype wire

// ### pcd_top.sv
// Behaviour
// R1: Prescalers divide by 1, 2, 4, 8
// R2: Enable mode: pin A gates reference output
// R3: Pin A power-down mode overrides enable mode
// R4: Mux mode: pin A picks master or prescaler
// R5: Source select fixes enabled reference frequency
// R6: All mode bits zero: reference circuitry off
// R7: Pin B: power-down or main output enable
// R8: Outputs go high-impedance only while low
// R9: Power-down disables outputs before shutting down
// R10: Outputs held off until clock settles
// R11: No programming while powered down
// R12: Master holds power-down request long enough
// R13: Main divider divides by field plus two
// R14: Master writes reserved bits as zero
// R15: Select bits form low slave address bits
// R16: Auto commit unless deferred commit set
// R17: Bus register write always commits everything
// R18: Start and stop detected with clock high
// R19: Bytewise transfer, ninth bit acknowledges
// R20: Acknowledge held low over clock high
// R21: Refuse every transfer while commit busy
// R22: Unacknowledged read byte ends, line released
// R23: Works at standard and fast rates
// R24: Bypass routes prescaler straight to main
// R25: Command byte selects the target register
// R26: Commit command copies registers when deferred
// R27: Acknowledge only matching address; lsb reads
// R28: Setting changes land on period boundaries
`timescale 1ns/1ps
`default_nettype none
module pcd_top import pcd_pkg::*; #(
   parameter int STAB_CYCLES = STAB_REF_CYCLES,
   parameter int EE_BUSY_CYCLES = EE_BUSY_REF_CYCLES,
   parameter logic [3:0] TYPE_CODE = TYPE_CODE_DFLT // Arbitrary value
) (
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   input wire logic I_CONTROL_PIN_A,
   input wire logic I_CONTROL_PIN_B,
   input wire logic I_SCL,
   input wire logic I_SDA,
   output logic O_SDA,
   output logic O_SDA_OE,
   output logic O_REFERENCE_CLOCK_OUT,
   output logic O_REFERENCE_CLOCK_OE,
   output logic O_MAIN_CLOCK_OUT,
   output logic O_MAIN_CLOCK_OE,
   output logic O_NV_BUSY
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [3:0] q1_ff, q2_ff, q3_ff; // Three-stage chains
   logic [3:0] flt_ff; // Accepted levels
   logic [3:0] flt_d_ff; // Accepted levels one cycle back

   // A level is taken only once stages two and three agree; at 40 MHz the
   // filter adds 100 ns, well inside a 400 kHz low phase
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         q1_ff <= SYNC_RST;
         q2_ff <= SYNC_RST;
         q3_ff <= SYNC_RST;
         flt_ff <= SYNC_RST;
         flt_d_ff <= SYNC_RST;
      end else begin
         q1_ff <= {I_CONTROL_PIN_B, I_CONTROL_PIN_A, I_SDA, I_SCL};
         q2_ff <= q1_ff;
         q3_ff <= q2_ff;
         for (int i = 0; i < 4; i++) begin
            flt_ff[i] <= (q2_ff[i] == q3_ff[i]) ? q3_ff[i] : flt_ff[i]; // R23
         end
         flt_d_ff <= flt_ff;
      end
   end

   logic scl, sda, pin_a, pin_b;
   logic scl_rise, scl_fall, start_evt, stop_evt;
   assign scl = flt_ff[IX_SCL];
   assign sda = flt_ff[IX_SDA];
   assign pin_a = flt_ff[IX_PA];
   assign pin_b = flt_ff[IX_PB];
   assign scl_rise = scl && !flt_d_ff[IX_SCL];
   assign scl_fall = !scl && flt_d_ff[IX_SCL];
   // Data moving under a steady high clock is a bus condition
   assign start_evt = scl && flt_d_ff[IX_SCL] && !sda && flt_d_ff[IX_SDA]; // R18
   assign stop_evt = scl && flt_d_ff[IX_SCL] && sda && !flt_d_ff[IX_SDA]; // R18

   // ----------------------------------------
   // Registers and mode decode
   // ----------------------------------------
   logic [15:0] mux_ff; // Output control word
   logic [15:0] div_ff; // Divisor word
   logic [7:0] bus_ff; // Bus configuration
   pcd_mode_t mode;
   logic ref_off, mux_mode, pd_req;
   assign mode = pcd_mode_t'(mux_ff[MODE_MSB:MODE_LSB]);
   // Enable, source select and pin A power-down bits clear: pin A is only a shutdown input
   assign ref_off = !mode.en_mode && !mode.src_sel && !mode.pdn_a; // R6
   assign mux_mode = !mode.en_mode && mode.src_sel && !mode.pdn_a; // R4
   // Both pins are ORed into one device shutdown request
   assign pd_req = (pin_a && (mode.pdn_a || ref_off)) || (pin_b && mode.pdn_b); // R3 R7

   // ----------------------------------------
   // Power sequencing
   // ----------------------------------------
   pcd_pw_t pw_ff;
   logic [23:0] stab_cnt_ff; // Settling counter
   logic ref_oe_ff, main_oe_ff;
   logic act, down;
   assign act = (pw_ff == PW_ACT);
   assign down = (pw_ff == PW_DOWN);

   // Power-up and each wake start in the settling state
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pw_ff <= PW_WARM;
         stab_cnt_ff <= '0;
      end else begin
         unique case (pw_ff)
            PW_WARM: begin
               // Outputs stay off until the oscillator has settled
               if (pd_req) begin
                  pw_ff <= PW_DRAIN;
               end else if (stab_cnt_ff == 24'(STAB_CYCLES - 1)) begin
                  pw_ff <= PW_ACT; // R10
               end else begin
                  stab_cnt_ff <= stab_cnt_ff + 24'd1;
               end
            end
            PW_ACT: begin
               if (pd_req) begin
                  pw_ff <= PW_DRAIN;
               end
            end
            PW_DRAIN: begin
               // Wait for both outputs to be parked before shutting down
               if (!ref_oe_ff && !main_oe_ff) begin
                  pw_ff <= PW_DOWN; // R9
               end
            end
            PW_DOWN: begin
               if (!pd_req) begin
                  pw_ff <= PW_WARM;
                  stab_cnt_ff <= '0; // R10
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Output clock path
   // ----------------------------------------
   logic ref_want, main_want;
   logic [HALF_W-1:0] ref_half, main_half, n_plus2, m_main;
   logic ref_clk, main_clk;

   // Pin A is active low as an enable; power-down mode keeps it on
   assign ref_want = act && (mode.pdn_a || (mode.en_mode ? !pin_a : mode.src_sel)); // R2 R3
   assign main_want = act && (mode.pdn_b || !pin_b); // R7
   // Mux mode lets pin A pick the source, else the select bit fixes it
   assign ref_half = ((mux_mode ? pin_a : mode.src_sel) ? // R4 R5
      HALF_W'(pre_half(mode.ref_pre)) : HALF_W'(1)); // R1
   assign m_main = HALF_W'(pre_half(mode.main_pre)); // R1
   assign n_plus2 = HALF_W'(div_ff[N_MSB:N_LSB]) + HALF_W'(2); // R13
   assign main_half = mode.bypass ? m_main : n_plus2 * m_main; // R24

   pcd_clk_gen #(.W(HALF_W)) u_ref_gen (
      .i_ref_clk(I_REF_CLK),
      .i_rst_b(I_RST_B),
      .i_run(!down && !ref_off), // R6
      .i_half(ref_half),
      .o_clk(ref_clk)
   );

   pcd_clk_gen #(.W(HALF_W)) u_main_gen (
      .i_ref_clk(I_REF_CLK),
      .i_rst_b(I_RST_B),
      .i_run(!down),
      .i_half(main_half),
      .o_clk(main_clk)
   );

   // Enables move only while the clock is low, so no pulse is cut short
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ref_oe_ff <= 1'b0;
         main_oe_ff <= 1'b0;
      end else begin
         if (!ref_clk) begin
            ref_oe_ff <= ref_want; // R8
         end
         if (!main_clk) begin
            main_oe_ff <= main_want; // R8
         end
      end
   end

   // ----------------------------------------
   // Serial slave
   // ----------------------------------------
   pcd_i2c_t st_ff;
   logic [7:0] sh_ff; // Shift register, both directions
   logic [3:0] bit_ff; // Bits moved in this byte
   logic addr_ph_ff, cmd_ph_ff, rw_ff, idx_ff, sda_oe_ff, sda_out_ff;
   logic [7:0] cmd_ff; // Current command
   logic busy_ff; // Nonvolatile write in progress
   logic byte_end, ack_now, wr_en, cmd_evt;
   logic [7:0] rd_byte;

   assign byte_end = (st_ff == I_RX) && scl_fall && (bit_ff == 4'd8); // R19
   // Refuse everything while committing or powered down
   assign ack_now = !busy_ff && !down && // R11 R21
      (!addr_ph_ff || sh_ff[7:1] == {TYPE_CODE, bus_ff[BUS_SEL_MSB:0]}); // R15 R27
   assign wr_en = byte_end && ack_now && !addr_ph_ff && !cmd_ph_ff;
   assign cmd_evt = byte_end && ack_now && !addr_ph_ff && cmd_ph_ff;

   // Byte returned for a read, first byte is the high half
   always_comb begin
      case (cmd_ff)
         CMD_DIV: rd_byte = idx_ff ? div_ff[7:0] : div_ff[15:8]; // R25
         CMD_MUX: rd_byte = idx_ff ? mux_ff[7:0] : mux_ff[15:8];
         CMD_BUS: rd_byte = idx_ff ? 8'h00 : bus_ff;
         default: rd_byte = 8'h00;
      endcase
   end

   // Protocol engine; data changes only on falling clock edges
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_ff <= I_IDLE;
         sh_ff <= 8'h00;
         bit_ff <= 4'd0;
         addr_ph_ff <= 1'b0;
         cmd_ph_ff <= 1'b0;
         rw_ff <= 1'b0;
         idx_ff <= 1'b0;
         cmd_ff <= 8'h00;
         sda_oe_ff <= 1'b0;
         sda_out_ff <= 1'b0;
      end else if (start_evt) begin
         // Start or repeated start: next byte is an address
         st_ff <= I_RX;
         bit_ff <= 4'd0;
         addr_ph_ff <= 1'b1; // R18
         sda_oe_ff <= 1'b0;
      end else if (stop_evt) begin
         st_ff <= I_IDLE; // R18
         sda_oe_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            I_IDLE: begin
               sda_oe_ff <= 1'b0;
            end
            I_RX: begin
               if (scl_rise && bit_ff != 4'd8) begin
                  sh_ff <= {sh_ff[6:0], sda};
                  bit_ff <= bit_ff + 4'd1;
               end else if (byte_end) begin
                  if (ack_now) begin
                     sda_oe_ff <= 1'b1; // R20
                     st_ff <= I_ACK;
                     if (addr_ph_ff) begin
                        rw_ff <= sh_ff[0]; // R27
                        cmd_ph_ff <= !sh_ff[0];
                        idx_ff <= 1'b0;
                        addr_ph_ff <= 1'b0;
                     end else if (cmd_ph_ff) begin
                        cmd_ff <= sh_ff; // R25
                        cmd_ph_ff <= 1'b0;
                     end else begin
                        idx_ff <= 1'b1;
                     end
                  end else begin
                     // Not acknowledged: stay off the bus until a start
                     st_ff <= I_IDLE; // R21
                  end
               end
            end
            I_ACK: begin
               // Low held through the whole acknowledge high phase
               if (scl_fall) begin
                  if (rw_ff) begin
                     sda_oe_ff <= !rd_byte[7];
                     sh_ff <= {rd_byte[6:0], 1'b0};
                     bit_ff <= 4'd1;
                     idx_ff <= 1'b1;
                     st_ff <= I_TX;
                  end else begin
                     sda_oe_ff <= 1'b0; // R19
                     bit_ff <= 4'd0;
                     st_ff <= I_RX;
                  end
               end
            end
            I_TX: begin
               if (scl_fall) begin
                  if (bit_ff == 4'd8) begin
                     sda_oe_ff <= 1'b0;
                     st_ff <= I_RACK;
                  end else begin
                     sda_oe_ff <= !sh_ff[7];
                     sh_ff <= {sh_ff[6:0], 1'b0};
                     bit_ff <= bit_ff + 4'd1;
                  end
               end
            end
            I_RACK: begin
               if (scl_rise && sda) begin
                  st_ff <= I_IDLE; // R22
               end else if (scl_fall) begin
                  sda_oe_ff <= !rd_byte[7];
                  sh_ff <= {rd_byte[6:0], 1'b0};
                  bit_ff <= 4'd1;
                  st_ff <= I_TX;
               end
            end
         endcase
      end
   end

   // Register writes; bytes past the register width rewrite the low byte of div and mux, and are dropped for bus
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         mux_ff <= MUX_RST;
         div_ff <= DIV_RST;
         bus_ff <= BUS_RST;
      end else if (wr_en) begin
         case (cmd_ff)
            CMD_DIV: begin
               if (idx_ff) div_ff[7:0] <= sh_ff; else div_ff[15:8] <= sh_ff; // R25
            end
            CMD_MUX: begin
               if (idx_ff) mux_ff[7:0] <= sh_ff; else mux_ff[15:8] <= sh_ff;
            end
            CMD_BUS: begin
               if (!idx_ff) bus_ff <= sh_ff;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Nonvolatile commit
   // ----------------------------------------
   logic wrote_ff, bus_wr_ff, pend_ff, commit;
   logic [23:0] ee_cnt_ff;
   assign commit = stop_evt && ((wrote_ff && !bus_ff[BUS_WC_BIT]) || bus_wr_ff || pend_ff); // R16 R17 R26

   // Commit is taken at the stop so a multi-byte word lands whole
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         wrote_ff <= 1'b0;
         bus_wr_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else if (stop_evt) begin
         wrote_ff <= 1'b0;
         bus_wr_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else begin
         if (wr_en) wrote_ff <= 1'b1;
         if (wr_en && cmd_ff == CMD_BUS) bus_wr_ff <= 1'b1; // R17
         if (cmd_evt && sh_ff == CMD_COMMIT && bus_ff[BUS_WC_BIT]) pend_ff <= 1'b1; // R26
      end
   end

   // Busy timer for the array write
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         busy_ff <= 1'b0;
         ee_cnt_ff <= '0;
      end else if (commit) begin
         busy_ff <= 1'b1;
         ee_cnt_ff <= '0;
      end else if (busy_ff) begin
         if (ee_cnt_ff == 24'(EE_BUSY_CYCLES - 1)) busy_ff <= 1'b0;
         else ee_cnt_ff <= ee_cnt_ff + 24'd1;
      end
   end

   assign O_SDA = sda_out_ff;
   assign O_SDA_OE = sda_oe_ff;
   assign O_REFERENCE_CLOCK_OUT = ref_clk;
   assign O_REFERENCE_CLOCK_OE = ref_oe_ff;
   assign O_MAIN_CLOCK_OUT = main_clk;
   assign O_MAIN_CLOCK_OE = main_oe_ff;
   assign O_NV_BUSY = busy_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);

   chk_ref_oe_low: assert property ($changed(ref_oe_ff) |-> !$past(ref_clk)) // R8
      else $error("reference enable moved while clock high");
   chk_main_oe_low: assert property ($changed(main_oe_ff) |-> !$past(main_clk)) // R8
      else $error("main enable moved while clock high");
   chk_down_order: assert property ($rose(down) |-> $past(!ref_oe_ff && !main_oe_ff)) // R9
      else $error("shutdown before outputs parked");
   chk_settle_time: assert property ($rose(act) |-> $past(stab_cnt_ff) == 24'(STAB_CYCLES - 1)) // R10
      else $error("outputs released before settling");
   chk_settle_off: assert property ((pw_ff == PW_WARM) |=> !ref_oe_ff && !main_oe_ff) // R10
      else $error("output enabled while settling");
   chk_down_no_write: assert property (down |-> !wr_en) // R11
      else $error("register written while powered down");
   chk_busy_nack: assert property ((byte_end && busy_ff) |=> !sda_oe_ff ##1 (st_ff == I_IDLE || start_evt)) // R21
      else $error("transfer acknowledged while busy");
   chk_ack_hold: assert property ((st_ff == I_ACK && scl) |-> sda_oe_ff) // R20
      else $error("acknowledge released during clock high");
   chk_ref_off: assert property (ref_off ##1 ref_off |=> !ref_oe_ff && !ref_clk) // R6
      else $error("reference output active in shutdown-only mode");
   chk_commit_busy: assert property (commit |=> busy_ff [*2]) // R16
      else $error("commit did not start busy time");

   cov_read_byte: cover property ((st_ff == I_TX) ##1 (st_ff == I_RACK));
   cov_commit: cover property (commit);
   cov_power_down: cover property ($rose(down));
   cov_wake: cover property ($rose(act));
endmodule
`default_nettype wire

// ### pcd_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model: lines move only after falling clock edges
module pcd_master #(
   parameter int Q = 25 // Quarter bit in clocks: 400 kHz at 40 MHz
) (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low // Pulls the wire low, else pull-up wins
);
   initial o_scl = 1'b1;
   initial o_sda_low = 1'b0;
   // Quarter bit in use; the bench may stretch it for a standard-rate transfer
   int qtr = Q;
   // One bus phase, held for a quarter bit
   task automatic ph(input logic c, input logic d);
      o_scl = c;
      o_sda_low = !d;
      repeat (qtr) @(negedge i_clk);
   endtask
   // Start or repeated start: data falls while clock high
   task automatic start();
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
   endtask
   // Stop: data rises while clock high, bus left idle
   task automatic stop();
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   // Eight bits msb first, then the acknowledge slot; a 1 releases the wire
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         ph(1'b0, d[i]);
         ph(1'b1, d[i]);
         q[i] = i_sda; // Mid high phase, where data must be stable
         ph(1'b1, d[i]);
         ph(1'b0, d[i]);
      end
   endtask
endmodule
`default_nettype wire

// ### programmable_clock_divider_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module programmable_clock_divider_cfg_tb import pcd_pkg::*;;
   logic clk, rst_b, pin_a, pin_b, scl, sda_low, sda_o, sda_oe;
   logic ref_out, ref_oe, main_out, main_oe, busy;
   wire sda = !(sda_low || (sda_oe && !sda_o)); // Open drain with pull-up
   int bad_count, comparisons;
   logic [1:0] po; // Last main enable and level
   localparam logic [7:0] AW = {TYPE_CODE_DFLT, 3'b000, 1'b0};
   // Short settle and busy times keep the run brief
   pcd_top #(.STAB_CYCLES(20), .EE_BUSY_CYCLES(1500)) u_dut (
      .I_REF_CLK(clk), .I_RST_B(rst_b), .I_CONTROL_PIN_A(pin_a), .I_CONTROL_PIN_B(pin_b),
      .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o), .O_SDA_OE(sda_oe),
      .O_REFERENCE_CLOCK_OUT(ref_out), .O_REFERENCE_CLOCK_OE(ref_oe),
      .O_MAIN_CLOCK_OUT(main_out), .O_MAIN_CLOCK_OE(main_oe), .O_NV_BUSY(busy));
   pcd_master u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic close_out();
      $display("bad_count %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic dly(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic oe(input logic r, input logic m);
      chk(16'({ref_oe, main_oe}), 16'({r, m}));
   endtask
   // Write transfer; bytes after the address only if it was acknowledged
   task automatic wr(input logic [7:0] a, input logic [7:0] c, input int n, input logic [15:0] d,
      input logic ea, input logic eb);
      logic [8:0] q;
      u_mst.start();
      u_mst.xfer({a, 1'b1}, q);
      chk(16'(!q[0]), 16'(ea));
      if (!q[0]) begin
         u_mst.xfer({c, 1'b1}, q);
         for (int i = 0; i < n; i++) u_mst.xfer({(i == 0) ? d[15:8] : d[7:0], 1'b1}, q);
      end
      u_mst.stop();
      dly(8);
      chk(16'(busy), 16'(eb));
   endtask
   // Command, repeated start, two bytes read back
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      logic [8:0] q, r;
      u_mst.start();
      u_mst.xfer({AW, 1'b1}, q);
      u_mst.xfer({c, 1'b1}, q);
      u_mst.start();
      u_mst.xfer({AW | 8'h01, 1'b1}, q);
      u_mst.xfer(9'h1FE, q);
      u_mst.xfer(9'h1FF, r);
      u_mst.stop();
      chk({q[8:1], r[8:1]}, e);
   endtask
   // Bounded wait for the nonvolatile write to finish
   task automatic idle();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) dly(1);
      chk(16'(busy), 16'h0000);
   endtask
   // Period between third and fourth rising edge; up to two edges seen
   // before a setting change lands may still carry the old period
   task automatic per(input bit s, input int e);
      logic c, l;
      int k, t0;
      l = 1'b1;
      k = 0;
      t0 = 0;
      for (int i = 0; i < 3000 && k < 4; i++) begin
         dly(1);
         c = s ? main_out : ref_out;
         if (c === 1'b1 && l === 1'b0) begin
            k++;
            if (k == 3) t0 = i;
            if (k == 4) chk(16'(i - t0), 16'(e));
         end
         l = c;
      end
      if (k < 4) chk(16'(k), 16'h0004);
   endtask
   // Main enable may only drop after a low cycle
   always @(negedge clk) begin
      if (po[0] === 1'b1 && main_oe === 1'b0) chk(16'(po[1]), 16'h0000);
      po <= {main_out, main_oe};
   end
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      {pin_a, pin_b, rst_b} = 3'h0;
      bad_count = 0;
      comparisons = 0;
      dly(12);
      rst_b = 1'b1;
      dly(40);
      oe(1'b1, 1'b1);
      rd(CMD_MUX, 16'h1800);
      wr(AW, CMD_DIV, 2, 16'h0040, 1'b1, 1'b1);
      wr(AW, CMD_DIV, 2, 16'h0040, 1'b0, 1'b1);
      idle();
      // Every prescaler code, largest first, ending on the default
      for (int c = 3; c >= 0; c--) begin
         wr(AW, CMD_MUX, 2, {5'h03, 2'(c), 2'(c), 7'h00}, 1'b1, 1'b1);
         idle();
         per(1'b0, 2 << c);
         per(1'b1, 6 << c);
      end
      {pin_a, pin_b} = 2'h3;
      dly(30);
      oe(1'b0, 1'b0);
      {pin_a, pin_b} = 2'h0;
      dly(30);
      oe(1'b1, 1'b1);
      wr({TYPE_CODE_DFLT, 3'b101, 1'b0}, CMD_DIV, 0, 16'h0000, 1'b0, 1'b0);
      wr(AW, CMD_MUX, 2, 16'h1640, 1'b1, 1'b1);
      idle();
      per(1'b1, 2);
      pin_a = 1'b1;
      per(1'b0, 16);
      pin_a = 1'b0;
      per(1'b0, 2);
      wr(AW, CMD_MUX, 2, 16'h0000, 1'b1, 1'b1);
      idle();
      oe(1'b0, 1'b1);
      wr(AW, CMD_MUX, 2, 16'h3800, 1'b1, 1'b1);
      idle();
      pin_a = 1'b1;
      dly(40);
      oe(1'b0, 1'b0);
      wr(AW, CMD_DIV, 2, 16'h0000, 1'b0, 1'b0);
      // Shutdown request held far past two slow periods plus margin
      pin_a = 1'b0;
      dly(12);
      oe(1'b0, 1'b0);
      dly(60);
      oe(1'b1, 1'b1);
      wr(AW, CMD_BUS, 1, 16'h0800, 1'b1, 1'b1);
      idle();
      rd(CMD_BUS, 16'h0800);
      wr(AW, CMD_DIV, 2, 16'h0080, 1'b1, 1'b0);
      wr(AW, CMD_COMMIT, 0, 16'h0000, 1'b1, 1'b1);
      idle();
      // Last read back at the standard rate
      u_mst.qtr = 100;
      rd(CMD_DIV, 16'h0080);
      close_out();
   end
   // Hang guard, some 15% beyond the expected run length
   initial begin
      dly(98000);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
